// file: hw/sfb_unit.sv
// shift, bit-transfer, flag and control instruction unit of an 8-bit core
//
// Functional notes
// [RULE1] logical left shift in one cycle, bit 0 gets zero, Z C N V updated.
// [RULE2] logical right shift in one cycle, bit 7 gets zero, Z C N V updated.
// [RULE3] arithmetic right shift keeps bit 7, one cycle, Z C N V updated.
// [RULE4] rotate left through carry: bit 0 from C, C from bit 7, one cycle.
// [RULE5] rotate right through carry: bit 7 from C, C from bit 0, one cycle.
// [RULE6] bit store copies the selected source bit into T, nothing else.
// [RULE7] bit load copies T into the selected destination bit, no flag moves.
// [RULE8] sign set and sign clear force S to one or zero, nothing else.
// [RULE9] overflow set and clear force V to one or zero, nothing else.
// [RULE10] sleep takes one cycle then enters the configured low-power mode.
// [RULE11] watchdog restart takes one cycle and pulses the watchdog restart.
// [RULE12] break acts only when debug is enabled and changes no flag.
// [RULE13] flags not touched by an instruction keep their previous value.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "sfb_map.svh"
module sfb_unit
(
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // instruction issue from the decoder
    input  wire logic                  issue,
    input  wire sfb_pkg::sfb_op_t      op,
    input  wire logic [4:0]            dest_sel,
    input  wire logic [2:0]            bit_sel,
    input  wire logic [7:0]            operand,
    // debug enable strap-like level from the debug block
    input  wire logic                  debug_en,
    // wake from sleep (same clock domain)
    input  wire logic                  wake,
    // register port
    input  wire logic [3:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    // write back to the register file
    output logic                       wb_en,
    output logic      [4:0]            wb_sel,
    output logic      [7:0]            wb_data,
    // outputs to the rest of the core
    output logic      [7:0]            status_flags,
    output logic                       sleep_active,
    output sfb_pkg::sfb_sleep_t        sleep_mode,
    output logic                       watchdog_restart,
    output logic                       debug_break
);
    import sfb_pkg::*;

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    logic [7:0]  flags_r;
    logic [7:0]  flags_nxt;
    logic [7:0]  sleepcfg_r;
    logic [7:0]  lastres_r;
    logic [7:0]  brkcnt_r;
    logic        wb_en_r;
    logic [4:0]  wb_sel_r;
    logic [7:0]  wb_data_r;
    logic        sleep_r;
    logic        wdog_r;
    logic        brk_r;
    logic [7:0]  rdata_r;

    logic [7:0]  sh_result;
    logic        sh_c;
    logic        sh_z;
    logic        sh_n;
    logic        sh_v;
    logic        sh_s;

    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    function automatic logic is_shift(input sfb_op_t o);
        is_shift = (o == SFB_OP_SHIFT_LEFT) || (o == SFB_OP_SHIFT_RIGHT) ||
                   (o == SFB_OP_SHIFT_RIGHT_ARITH) ||
                   (o == SFB_OP_ROTATE_LEFT) || (o == SFB_OP_ROTATE_RIGHT);
    endfunction

    function automatic logic [7:0] put_bit(input logic [7:0] v,
                                           input logic [2:0] pos,
                                           input logic       b);
        logic [7:0] r;
        r      = v;
        r[pos] = b;
        put_bit = r;
    endfunction

    // -------------------------------------------------------------------------
    // datapath
    // -------------------------------------------------------------------------
    sfb_shifter u_shifter
    (
        .op        (op),
        .operand   (operand),
        .carry_in  (flags_r[`SFB_FLAG_C]),
        .result    (sh_result),
        .carry_out (sh_c),
        .zero_out  (sh_z),
        .neg_out   (sh_n),
        .ovf_out   (sh_v),
        .sign_out  (sh_s)
    );

    // -------------------------------------------------------------------------
    // next flag value
    // -------------------------------------------------------------------------
    always_comb
    begin
        flags_nxt = flags_r;                                    // [RULE13]
        if (issue && !sleep_r)
        begin
            case (op)
                SFB_OP_SHIFT_LEFT, SFB_OP_SHIFT_RIGHT,
                SFB_OP_SHIFT_RIGHT_ARITH, SFB_OP_ROTATE_LEFT,
                SFB_OP_ROTATE_RIGHT:
                begin
                    // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
                    flags_nxt[`SFB_FLAG_C] = sh_c;
                    flags_nxt[`SFB_FLAG_Z] = sh_z;
                    flags_nxt[`SFB_FLAG_N] = sh_n;
                    flags_nxt[`SFB_FLAG_V] = sh_v;
                    flags_nxt[`SFB_FLAG_S] = sh_s;
                end
                SFB_OP_BIT_TO_T:
                    flags_nxt[`SFB_FLAG_T] = operand[bit_sel];  // [RULE6]
                SFB_OP_SIGN_SET:
                    flags_nxt[`SFB_FLAG_S] = 1'b1;              // [RULE8]
                SFB_OP_SIGN_CLEAR:
                    flags_nxt[`SFB_FLAG_S] = 1'b0;              // [RULE8]
                SFB_OP_OVF_SET:
                    flags_nxt[`SFB_FLAG_V] = 1'b1;              // [RULE9]
                SFB_OP_OVF_CLEAR:
                    flags_nxt[`SFB_FLAG_V] = 1'b0;              // [RULE9]
                default:
                    flags_nxt = flags_r;      // [RULE7] [RULE10] [RULE11]
            endcase
        end
        else if (reg_wr && reg_addr == `SFB_REG_FLAGS)
        begin
            flags_nxt = reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            flags_r <= `SFB_FLAGS_RST;
        else
            flags_r <= flags_nxt;
    end

    // -------------------------------------------------------------------------
    // register write back
    // -------------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wb_en_r   <= 1'b0;
            wb_sel_r  <= 5'h00;
            wb_data_r <= 8'h00;
        end
        else
        begin
            wb_en_r <= 1'b0;
            if (issue && !sleep_r && is_shift(op))
            begin
                wb_en_r   <= 1'b1;          // [RULE1] [RULE2] [RULE3]
                wb_sel_r  <= dest_sel;      // [RULE4] [RULE5]
                wb_data_r <= sh_result;
            end
            else if (issue && !sleep_r && op == SFB_OP_T_TO_BIT)
            begin
                wb_en_r   <= 1'b1;
                wb_sel_r  <= dest_sel;
                wb_data_r <= put_bit(operand, bit_sel,
                                     flags_r[`SFB_FLAG_T]);   // [RULE7]
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            lastres_r <= 8'h00;
        else if (issue && !sleep_r && is_shift(op))
            lastres_r <= sh_result;
    end

    // -------------------------------------------------------------------------
    // control instructions
    // -------------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            sleep_r <= 1'b0;
        else if (sleep_r && wake)
            sleep_r <= 1'b0;
        else if (issue && op == SFB_OP_SLEEP &&
                 sleepcfg_r[2:1] != SFB_SLP_NONE)
            sleep_r <= 1'b1;                                   // [RULE10]
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            wdog_r <= 1'b0;
        else
            wdog_r <= issue && !sleep_r &&
                      op == SFB_OP_WDOG_RESTART;              // [RULE11]
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            brk_r <= 1'b0;
        else
            brk_r <= issue && !sleep_r && op == SFB_OP_BREAK &&
                     debug_en;                                 // [RULE12]
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            brkcnt_r <= 8'h00;
        else if (reg_wr && reg_addr == `SFB_REG_BRKCNT)
            brkcnt_r <= 8'h00;
        else if (issue && !sleep_r && op == SFB_OP_BREAK && debug_en)
            brkcnt_r <= 8'(brkcnt_r + 8'h01);
    end

    // -------------------------------------------------------------------------
    // register port
    // -------------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            sleepcfg_r <= `SFB_SLEEPCFG_RST;
        else if (reg_wr && reg_addr == `SFB_REG_SLEEPCFG)
            sleepcfg_r <= {5'h00, reg_wdata[2:0]};
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata_r <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `SFB_REG_FLAGS:    rdata_r <= flags_r;
                `SFB_REG_SLEEPCFG: rdata_r <= sleepcfg_r;
                `SFB_REG_STATUS:   rdata_r <= {5'h00, debug_en, brk_r,
                                               sleep_r};
                `SFB_REG_LASTRES:  rdata_r <= lastres_r;
                `SFB_REG_BRKCNT:   rdata_r <= brkcnt_r;
                default:           rdata_r <= 8'h00;
            endcase
        end
        else
            rdata_r <= 8'h00;
    end

    // -------------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------------
    assign reg_rdata        = rdata_r;
    assign wb_en            = wb_en_r;
    assign wb_sel           = wb_sel_r;
    assign wb_data          = wb_data_r;
    assign status_flags     = flags_r;
    assign sleep_active     = sleep_r;
    assign sleep_mode       = sfb_sleep_t'(sleepcfg_r[2:1]);
    assign watchdog_restart = wdog_r;
    assign debug_break      = brk_r;

endmodule

// file: common/sfb_map.svh
// register offsets, flag positions and timing counts of the shift/flag unit
`ifndef SFB_MAP_SVH
`define SFB_MAP_SVH

// -----------------------------------------------------------------------------
// status flag bit positions
// -----------------------------------------------------------------------------
`define SFB_FLAG_C       3'd0
`define SFB_FLAG_Z       3'd1
`define SFB_FLAG_N       3'd2
`define SFB_FLAG_V       3'd3
`define SFB_FLAG_S       3'd4
`define SFB_FLAG_H       3'd5
`define SFB_FLAG_T       3'd6
`define SFB_FLAG_I       3'd7

// -----------------------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------------------
`define SFB_REG_FLAGS    4'h0
`define SFB_REG_SLEEPCFG 4'h1
`define SFB_REG_STATUS   4'h2
`define SFB_REG_LASTRES  4'h3
`define SFB_REG_BRKCNT   4'h4

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define SFB_FLAGS_RST    8'h00
`define SFB_SLEEPCFG_RST 8'h00

// -----------------------------------------------------------------------------
// timing: every instruction of this unit takes one cycle
// -----------------------------------------------------------------------------
`define SFB_INSTR_CYCLES 1

`endif

// file: common/sfb_pkg.sv
// types of the shift/flag unit
package sfb_pkg;

    typedef enum logic [3:0]
    {
        SFB_OP_NOP              = 4'h0,
        SFB_OP_SHIFT_LEFT       = 4'h1,
        SFB_OP_SHIFT_RIGHT      = 4'h2,
        SFB_OP_SHIFT_RIGHT_ARITH= 4'h3,
        SFB_OP_ROTATE_LEFT      = 4'h4,
        SFB_OP_ROTATE_RIGHT     = 4'h5,
        SFB_OP_BIT_TO_T         = 4'h6,
        SFB_OP_T_TO_BIT         = 4'h7,
        SFB_OP_SIGN_SET         = 4'h8,
        SFB_OP_SIGN_CLEAR       = 4'h9,
        SFB_OP_OVF_SET          = 4'hA,
        SFB_OP_OVF_CLEAR        = 4'hB,
        SFB_OP_SLEEP            = 4'hC,
        SFB_OP_WDOG_RESTART     = 4'hD,
        SFB_OP_BREAK            = 4'hE
    } sfb_op_t;

    typedef enum logic [1:0]
    {
        SFB_SLP_NONE  = 2'h0,
        SFB_SLP_IDLE  = 2'h1,
        SFB_SLP_DEEP  = 2'h2,
        SFB_SLP_STBY  = 2'h3
    } sfb_sleep_t;

endpackage

// file: hw/sfb_shifter.sv
// combinational shift/rotate datapath with flag results
`timescale 1ns/1ps
module sfb_shifter
    import sfb_pkg::*;
(
    input  wire sfb_pkg::sfb_op_t op,
    input  wire logic [7:0]       operand,
    input  wire logic             carry_in,
    output logic      [7:0]       result,
    output logic                  carry_out,
    output logic                  zero_out,
    output logic                  neg_out,
    output logic                  ovf_out,
    output logic                  sign_out
);

    // -------------------------------------------------------------------------
    // shift and rotate
    // -------------------------------------------------------------------------
    always_comb
    begin
        result    = operand;
        carry_out = carry_in;
        case (op)
            SFB_OP_SHIFT_LEFT:
            begin
                result    = {operand[6:0], 1'b0};
                carry_out = operand[7];
            end
            SFB_OP_SHIFT_RIGHT:
            begin
                result    = {1'b0, operand[7:1]};
                carry_out = operand[0];
            end
            SFB_OP_SHIFT_RIGHT_ARITH:
            begin
                result    = {operand[7], operand[7:1]};
                carry_out = operand[0];
            end
            SFB_OP_ROTATE_LEFT:
            begin
                result    = {operand[6:0], carry_in};
                carry_out = operand[7];
            end
            SFB_OP_ROTATE_RIGHT:
            begin
                result    = {carry_in, operand[7:1]};
                carry_out = operand[0];
            end
            default:
            begin
                result    = operand;
                carry_out = carry_in;
            end
        endcase
    end

    // -------------------------------------------------------------------------
    // flags: overflow is negative xor carry, sign is negative xor overflow
    // -------------------------------------------------------------------------
    always_comb
    begin
        zero_out = (result == 8'h00);
        neg_out  = result[7];
        ovf_out  = result[7] ^ carry_out;
        sign_out = result[7] ^ (result[7] ^ carry_out);
    end

endmodule

// file: verif/sfb_unit_props.sv
// port assertions of the shift/flag unit
`timescale 1ns/1ps
module sfb_unit_props
    import sfb_pkg::*;
(
    input wire logic               clk,
    input wire logic               nrst,
    input wire logic               issue,
    input wire sfb_pkg::sfb_op_t   op,
    input wire logic [2:0]         bit_sel,
    input wire logic [7:0]         operand,
    input wire logic               debug_en,
    input wire logic               wake,
    input wire logic               wb_en,
    input wire logic [7:0]         wb_data,
    input wire logic [7:0]         status_flags,
    input wire logic               sleep_active,
    input wire sfb_pkg::sfb_sleep_t sleep_mode,
    input wire logic               watchdog_restart,
    input wire logic               debug_break
);
    logic [7:0] opd_q, flg_q, exp_r, fmask;
    logic [3:0] op_q;
    logic [2:0] bit_q;
    logic       fire, fire_q, dbg_q, exp_c, is_sh, is_fl;
    assign fire = issue && !sleep_active;
    assign is_sh = fire && op inside {[SFB_OP_SHIFT_LEFT:SFB_OP_ROTATE_RIGHT]};
    assign is_fl = fire && op inside {[SFB_OP_SIGN_SET:SFB_OP_OVF_CLEAR]};
    assign fmask = op_q[1] ? 8'h08 : 8'h10;
    // inputs of the issuing cycle, seen one cycle later
    always_ff @(posedge clk)
    begin
        {opd_q, flg_q, bit_q, op_q} <= {operand, status_flags, bit_sel, op};
        {fire_q, dbg_q} <= {fire, debug_en};
    end
    always_comb
    begin
        case (op_q)
            SFB_OP_SHIFT_LEFT:        {exp_c, exp_r} = {opd_q, 1'b0};
            SFB_OP_SHIFT_RIGHT:       {exp_r, exp_c} = {1'b0, opd_q};
            SFB_OP_SHIFT_RIGHT_ARITH: {exp_r, exp_c} = {opd_q[7], opd_q};
            SFB_OP_ROTATE_LEFT:       {exp_c, exp_r} = {opd_q, flg_q[0]};
            default:                  {exp_r, exp_c} = {flg_q[0], opd_q};
        endcase
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    shift_res_a: assert property (
        is_sh |=> wb_en && wb_data == exp_r && status_flags[0] == exp_c)
        else $error("shift result wrong");
    shift_flag_a: assert property (
        is_sh |=> status_flags[1] == (wb_data == 8'h00)
            && status_flags[2] == wb_data[7]
            && status_flags[3] == (wb_data[7] ^ status_flags[0])
            && status_flags[4] == (status_flags[2] ^ status_flags[3])
            && status_flags[7:5] == flg_q[7:5])
        else $error("shift flags wrong");
    bit_store_a: assert property (
        fire && op == SFB_OP_BIT_TO_T |=>
            status_flags == {flg_q[7], opd_q[bit_q], flg_q[5:0]})
        else $error("bit store wrong");
    bit_load_a: assert property (
        fire && op == SFB_OP_T_TO_BIT |=> wb_en && status_flags == flg_q
            && wb_data == ((opd_q & ~(8'h01 << bit_q))
            | ({7'h00, flg_q[6]} << bit_q)))
        else $error("bit load wrong");
    flag_force_a: assert property (
        is_fl |=> status_flags == (op_q[0] ? flg_q & ~fmask : flg_q | fmask))
        else $error("flag force wrong");
    flags_kept_a: assert property (
        fire && op inside {SFB_OP_NOP, SFB_OP_SLEEP, SFB_OP_WDOG_RESTART,
            SFB_OP_BREAK} |=> $stable(status_flags))
        else $error("flags moved");
    wdog_pulse_a: assert property (
        watchdog_restart == (fire_q && op_q == SFB_OP_WDOG_RESTART))
        else $error("watchdog pulse wrong");
    brk_pulse_a: assert property (
        debug_break == (fire_q && op_q == SFB_OP_BREAK && dbg_q))
        else $error("break pulse wrong");
    sequence sleep_req_s;
        fire && op == SFB_OP_SLEEP && sleep_mode != SFB_SLP_NONE;
    endsequence
    sequence wake_up_s;
        sleep_active && wake;
    endsequence
    sleep_go_a: assert property (
        sleep_req_s |=> sleep_active)
        else $error("sleep not entered");
    sleep_wake_a: assert property (
        wake_up_s |=> !sleep_active)
        else $error("sleep not left");
    sleep_mute_a: assert property (
        sleep_active |=> !wb_en && !watchdog_restart && !debug_break)
        else $error("issue taken while asleep");
endmodule
bind sfb_unit sfb_unit_props u_props
(
    .clk(clk), .nrst(nrst), .issue(issue), .op(op), .bit_sel(bit_sel),
    .operand(operand), .debug_en(debug_en), .wake(wake), .wb_en(wb_en),
    .wb_data(wb_data), .status_flags(status_flags),
    .sleep_active(sleep_active), .sleep_mode(sleep_mode),
    .watchdog_restart(watchdog_restart), .debug_break(debug_break)
);

// file: verif/sfb_regfile_model.sv
// register file behind the write-back port of the shift/flag unit
`timescale 1ns/1ps
module sfb_regfile_model
(
    input  wire logic       clk,
    input  wire logic       wb_en,
    input  wire logic [4:0] wb_sel,
    input  wire logic [7:0] wb_data,
    input  wire logic [4:0] rd_sel,
    output logic      [7:0] rd_data
);
    logic [7:0] mem [32];
    // a write lands on the edge that samples the pulse
    always_ff @(posedge clk)
    begin
        if (wb_en)
        begin
            mem[wb_sel] <= wb_data;
        end
    end
    assign rd_data = mem[rd_sel];
endmodule

// file: verif/tb_sfb_unit.sv
// self-checking bench of the shift/flag unit
`timescale 1ns/1ps
`include "sfb_map.svh"
module tb_sfb_unit;
    import sfb_pkg::*;
    logic       clk = 1'b0, nrst = 1'b0, issue = 1'b0, wake = 1'b0;
    logic       debug_en = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    sfb_op_t    op = SFB_OP_NOP;
    logic [4:0] dest_sel = 5'h00, wb_sel;
    logic [2:0] bit_sel = 3'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] operand = 8'h00, reg_wdata = 8'h00, m, ef;
    logic [7:0] reg_rdata, wb_data, status_flags, rf_data;
    logic [7:0] opnd [4] = '{8'h81, 8'h00, 8'h40, 8'h01};
    logic       wb_en, sleep_active, watchdog_restart, debug_break;
    sfb_sleep_t sleep_mode;
    logic [15:0] e;
    int         mismatches = 0;
    int         checks_done = 0;
    initial forever #2.5 clk = ~clk;
    sfb_unit dut
    (
        .clk(clk), .nrst(nrst), .issue(issue), .op(op),
        .dest_sel(dest_sel), .bit_sel(bit_sel), .operand(operand),
        .debug_en(debug_en), .wake(wake), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .wb_en(wb_en), .wb_sel(wb_sel),
        .wb_data(wb_data), .status_flags(status_flags),
        .sleep_active(sleep_active), .sleep_mode(sleep_mode),
        .watchdog_restart(watchdog_restart), .debug_break(debug_break)
    );
    sfb_regfile_model rf
    (
        .clk(clk), .wb_en(wb_en), .wb_sel(wb_sel), .wb_data(wb_data),
        .rd_sel(dest_sel), .rd_data(rf_data)
    );
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        checks_done++;
        if (g !== x)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    // one register access; a read compares the data of the next cycle
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        if (!w)
            chk(reg_rdata, d);
    endtask
    task automatic run(input sfb_op_t o, input logic [2:0] b,
                       input logic [7:0] d);
        @(posedge clk);
        issue <= 1'b1;
        op <= o;
        bit_sel <= b;
        operand <= d;
        dest_sel <= dest_sel + 5'h01;
        @(posedge clk);
        issue <= 1'b0;
        #1;
    endtask
    // expected {flags, result} of a shift or rotate
    function automatic logic [15:0] shexp(sfb_op_t o, logic [7:0] d,
                                          logic [7:0] f);
        logic [7:0] r;
        logic       c;
        case (o)
            SFB_OP_SHIFT_LEFT:        {c, r} = {d, 1'b0};
            SFB_OP_SHIFT_RIGHT:       {r, c} = {1'b0, d};
            SFB_OP_SHIFT_RIGHT_ARITH: {r, c} = {d[7], d};
            SFB_OP_ROTATE_LEFT:       {c, r} = {d, f[0]};
            default:                  {r, c} = {f[0], d};
        endcase
        return {f[7:5], c, r[7] ^ c, r[7], r == 8'h00, c, r};
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #20000;
        mismatches++;
        results();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        ef = 8'h00;
        acc(1'b0, `SFB_REG_FLAGS, 8'h00);
        acc(1'b0, 4'hF, 8'h00);
        foreach (opnd[i])
            for (int k = 1; k < 6; k++)
            begin
                e = shexp(sfb_op_t'(k), opnd[i], ef);
                run(sfb_op_t'(k), 3'h0, opnd[i]);
                ef = e[15:8];
                chk({7'h00, wb_en}, 8'h01);
                chk(wb_data, e[7:0]);
                chk(status_flags, ef);
                @(posedge clk);
                #1;
                chk(rf_data, e[7:0]);
            end
        acc(1'b0, `SFB_REG_LASTRES, e[7:0]);
        run(SFB_OP_BIT_TO_T, 3'h7, 8'h80);
        ef = ef | 8'h40;
        chk(status_flags, ef);
        run(SFB_OP_T_TO_BIT, 3'h0, 8'h00);
        chk({wb_data[6:0], wb_en}, 8'h03);
        chk(status_flags, ef);
        run(SFB_OP_BIT_TO_T, 3'h0, 8'hFE);
        ef = ef & 8'hBF;
        chk(status_flags, ef);
        run(SFB_OP_T_TO_BIT, 3'h7, 8'hFF);
        chk(wb_data, 8'h7F);
        for (int k = 8; k < 12; k++)
        begin
            run(sfb_op_t'(k), 3'h0, 8'h00);
            m = k[1] ? 8'h08 : 8'h10;
            ef = k[0] ? ef & ~m : ef | m;
            chk(status_flags, ef);
        end
        run(SFB_OP_WDOG_RESTART, 3'h0, 8'h00);
        chk({watchdog_restart, status_flags[6:0]},
            {1'b1, ef[6:0]});
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk);
            debug_en <= k[0];
            run(SFB_OP_BREAK, 3'h0, 8'h00);
            chk({debug_break, status_flags[6:0]}, {k[0], ef[6:0]});
        end
        acc(1'b0, `SFB_REG_BRKCNT, 8'h01);
        acc(1'b0, `SFB_REG_STATUS, 8'h04);
        acc(1'b1, `SFB_REG_BRKCNT, 8'h5A);
        acc(1'b0, `SFB_REG_BRKCNT, 8'h00);
        run(SFB_OP_SLEEP, 3'h0, 8'h00);
        chk({7'h00, sleep_active}, 8'h00);
        acc(1'b1, `SFB_REG_SLEEPCFG, 8'h02);
        acc(1'b0, `SFB_REG_SLEEPCFG, 8'h02);
        run(SFB_OP_SLEEP, 3'h0, 8'h00);
        chk({5'h00, sleep_active, sleep_mode}, 8'h05);
        run(SFB_OP_SHIFT_LEFT, 3'h0, 8'h81);
        chk({wb_en, status_flags[6:0]}, {1'b0, ef[6:0]});
        acc(1'b0, `SFB_REG_STATUS, 8'h05);
        @(posedge clk);
        wake <= 1'b1;
        for (int n = 0; n < 8 && sleep_active; n++)
            @(posedge clk);
        wake <= 1'b0;
        #1;
        chk({7'h00, sleep_active}, 8'h00);
        acc(1'b0, `SFB_REG_FLAGS, ef);
        acc(1'b1, `SFB_REG_FLAGS, 8'hA5);
        acc(1'b0, `SFB_REG_FLAGS, 8'hA5);
        results();
    end
endmodule
